// [dcfm_top.sv]
// Purpose: Queue from port A to port B with two mailboxes and flags
// Assumes: Port clocks are inputs sampled by core_clk
// Notes:   Flags are active low, as on the pins of the original part
// Notes on behaviour
// - Sixty-four words of 36 bits are queued in order from port A to port B.
// - A port moves data only on its own rising clock edge qualified by its enables.
// - Each port is paced by its own clock and works whether the clocks are related or not.
// - Full and almost-full each pass two sync stages stepped by the port A clock.
// - Empty and almost-empty each pass two sync stages stepped by the port B clock.
// - Almost-full and almost-empty compare against a selected offset.
// - Two 36-bit mailboxes bypass the queue, one per direction, each with a new-mail flag.
// - Parity is checked passively and never blocks or alters a transfer.
// - A reader may ask for generated parity bits in place of the stored ones.
// - Parity runs over 9-bit bytes with the top bit as parity; odd sense when set.
// - A mailbox write drops its flag and blocks writes; a far-side read raises it.
// - Reset takes four edges of each port clock and latches the offset pick at release.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module dcfm_top #(
   parameter int DEPTH = dcfm_pkg::FIFO_DEPTH,
   parameter int WIDTH = dcfm_pkg::WORD_W
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   input  wire logic                      port_a_clock,
   input  wire logic                      a_side_select_n,
   input  wire logic                      a_side_gate,
   input  wire logic                      a_dir_select,
   input  wire logic                      a_mail_select,
   input  wire logic                      a_parity_gen,
   input  wire logic [WIDTH-1:0]          a_data_in,
   output logic      [WIDTH-1:0]          a_data_out,
   output logic                           a_data_oe,
   input  wire logic                      port_b_clock,
   input  wire logic                      b_side_select_n,
   input  wire logic                      b_side_gate,
   input  wire logic                      b_dir_select,
   input  wire logic                      b_mail_select,
   input  wire logic                      b_parity_gen,
   input  wire logic [WIDTH-1:0]          b_data_in,
   output logic      [WIDTH-1:0]          b_data_out,
   output logic                           b_data_oe,
   input  wire logic [1:0]                threshold_preset_pick,
   output logic                           full_flag_n,
   output logic                           almost_full_flag_n,
   output logic                           empty_flag_n,
   output logic                           almost_empty_flag_n,
   output logic                           mail_to_b_flag_n,
   output logic                           mail_to_a_flag_n,
   output logic                           a_parity_err_n,
   output logic                           b_parity_err_n,
   output logic                           irq,
   input  wire logic [dcfm_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic      [1:0]                s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [dcfm_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic      [31:0]               s_axi_rdata,
   output logic      [1:0]                s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);
   localparam int              PW    = $clog2(DEPTH) + 1;
   localparam int              AW    = dcfm_pkg::AXI_AW;
   localparam int              EW    = dcfm_pkg::EV_W;
   localparam logic [PW-1:0]   DEPTH_P = PW'(DEPTH);
   localparam logic [2:0]      EDGES = 3'(dcfm_pkg::RESET_EDGES);

   // Pointers carry one wrap bit, so the count field must hold DEPTH
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || PW > dcfm_pkg::CNT_FIELD_W
       || dcfm_pkg::OFFSET_PRESET[0] >= DEPTH
       || WIDTH % dcfm_pkg::BYTE_W != 0 || WIDTH > 32 + dcfm_pkg::BYTE_W * 4)
   begin : g_bad_params
      $error("dcfm_top: DEPTH or WIDTH not supported");
   end

   // Port clock edge detection and reset sequencing
   logic            a_clk_q;
   logic            b_clk_q;
   logic            hold_q;
   logic [2:0]      a_rcnt_q;
   logic [2:0]      b_rcnt_q;
   logic [PW-1:0]   offset_q;

   wire a_edge = port_a_clock & ~a_clk_q;
   wire b_edge = port_b_clock & ~b_clk_q;
   wire a_rdone = (a_rcnt_q == EDGES);
   wire b_rdone = (b_rcnt_q == EDGES);
   wire [PW-1:0] preset = PW'(dcfm_pkg::OFFSET_PRESET[threshold_preset_pick]);

   always_ff @(posedge core_clk)
   begin
      if (ce)
      begin
         a_clk_q <= port_a_clock;
         b_clk_q <= port_b_clock;
         if (rst)
         begin
            hold_q   <= 1'b1;
            a_rcnt_q <= '0;
            b_rcnt_q <= '0;
         end
         else if (hold_q)
         begin
            // Edges count from release, so any reset pulse length works
            a_rcnt_q <= a_rdone ? a_rcnt_q : a_rcnt_q + 3'(a_edge);
            b_rcnt_q <= b_rdone ? b_rcnt_q : b_rcnt_q + 3'(b_edge);
            if (a_rdone && b_rdone)
            begin
               hold_q   <= 1'b0;
               a_rcnt_q <= '0;
               b_rcnt_q <= '0;
               offset_q <= preset;
            end
         end
      end
   end

   // Port qualification
   wire a_xfer = a_edge & ~a_side_select_n & a_side_gate & ~hold_q;
   wire b_xfer = b_edge & ~b_side_select_n & b_side_gate & ~hold_q;
   wire a_wr   = a_xfer & a_dir_select;
   wire a_rd   = a_xfer & ~a_dir_select;
   wire b_wr   = b_xfer & b_dir_select;
   wire b_rd   = b_xfer & ~b_dir_select;

   // Queue storage and pointers
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wptr_q;
   logic [PW-1:0]    rptr_q;
   logic [1:0]       ff_sync_q;
   logic [1:0]       af_sync_q;
   logic [1:0]       ef_sync_q;
   logic [1:0]       ae_sync_q;

   wire [PW-1:0] count     = wptr_q - rptr_q;
   wire          full_raw  = (count == DEPTH_P);
   wire          empty_raw = (count == '0);
   wire          af_raw    = (DEPTH_P - count) <= offset_q;
   wire          ae_raw    = count <= offset_q;

   // Raw state also gates: flag lag cannot overrun
   wire fifo_wr_req = a_wr & ~a_mail_select;
   wire fifo_rd_req = b_rd & ~b_mail_select;
   wire fifo_wr     = fifo_wr_req & ff_sync_q[1] & ~full_raw;
   wire fifo_rd     = fifo_rd_req & ef_sync_q[1] & ~empty_raw;
   wire [WIDTH-1:0] fifo_head = mem_q[rptr_q[PW-2:0]];

   always_ff @(posedge core_clk)
   begin
      if (ce && fifo_wr)
      begin
         mem_q[wptr_q[PW-2:0]] <= a_data_in;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (ce)
      begin
         if (rst || hold_q)
         begin
            wptr_q    <= '0;
            rptr_q    <= '0;
            ff_sync_q <= 2'h0;
            af_sync_q <= 2'h3;
            ef_sync_q <= 2'h0;
            ae_sync_q <= 2'h0;
         end
         else
         begin
            wptr_q <= wptr_q + PW'(fifo_wr);
            rptr_q <= rptr_q + PW'(fifo_rd);
            if (a_edge)
            begin
               ff_sync_q <= {ff_sync_q[0], ~full_raw};
               af_sync_q <= {af_sync_q[0], ~af_raw};
            end
            if (b_edge)
            begin
               ef_sync_q <= {ef_sync_q[0], ~empty_raw};
               ae_sync_q <= {ae_sync_q[0], ~ae_raw};
            end
         end
      end
   end

   assign full_flag_n         = ff_sync_q[1];
   assign almost_full_flag_n  = af_sync_q[1];
   assign empty_flag_n        = ef_sync_q[1];
   assign almost_empty_flag_n = ae_sync_q[1];

   // Parity units; odd/even sense comes from the control register
   logic ctrl_odd_q;
   dcfm_par_if #(.W(WIDTH)) pa_if ();
   dcfm_par_if #(.W(WIDTH)) pb_if ();
   dcfm_parity #(.W(WIDTH)) u_par_a (.p(pa_if.unit));
   dcfm_parity #(.W(WIDTH)) u_par_b (.p(pb_if.unit));

   // Mailboxes
   logic [WIDTH-1:0] mail1_q;
   logic [WIDTH-1:0] mail2_q;
   logic             mail_to_b_flag_q;
   logic             mail_to_a_flag_q;

   wire mail1_wr = a_wr & a_mail_select & mail_to_b_flag_q;
   wire mail1_rd = b_rd & b_mail_select;
   wire mail2_wr = b_wr & b_mail_select & mail_to_a_flag_q;
   wire mail2_rd = a_rd & a_mail_select;
   wire [WIDTH-1:0] b_src = b_mail_select ? mail1_q : fifo_head;

   assign pa_if.chk_word = a_data_in;
   assign pa_if.gen_in   = mail2_q;
   assign pa_if.odd      = ctrl_odd_q;
   assign pb_if.chk_word = b_data_in;
   assign pb_if.gen_in   = b_src;
   assign pb_if.odd      = ctrl_odd_q;

   // Shared trees: a generating mailbox read set-up hides errors
   wire a_gen_setup = ~a_side_select_n & a_side_gate & ~a_dir_select & a_mail_select
                      & a_parity_gen;
   wire b_gen_setup = ~b_side_select_n & b_side_gate & ~b_dir_select & b_mail_select
                      & b_parity_gen;
   wire a_perr = pa_if.err & ~a_gen_setup;
   wire b_perr = pb_if.err & ~b_gen_setup;
   wire [WIDTH-1:0] a_rd_word = a_parity_gen ? pa_if.gen_out : mail2_q;
   wire [WIDTH-1:0] b_rd_word = b_parity_gen ? pb_if.gen_out : b_src;

   always_ff @(posedge core_clk)
   begin
      if (ce)
      begin
         a_data_oe <= ~a_side_select_n & ~a_dir_select;
         b_data_oe <= ~b_side_select_n & ~b_dir_select;
         if (rst || hold_q)
         begin
            mail_to_b_flag_q         <= 1'b1;
            mail_to_a_flag_q         <= 1'b1;
            a_parity_err_n <= 1'b1;
            b_parity_err_n <= 1'b1;
            a_data_out     <= '0;
            b_data_out     <= '0;
         end
         else
         begin
            a_parity_err_n <= ~a_perr;
            b_parity_err_n <= ~b_perr;
            if (mail1_wr)
            begin
               mail1_q <= a_data_in;
            end
            if (mail2_wr)
            begin
               mail2_q <= b_data_in;
            end
            mail_to_b_flag_q <= mail1_wr ? 1'b0 : (mail1_rd ? 1'b1 : mail_to_b_flag_q);
            mail_to_a_flag_q <= mail2_wr ? 1'b0 : (mail2_rd ? 1'b1 : mail_to_a_flag_q);
            if (mail2_rd)
            begin
               a_data_out <= a_rd_word;
            end
            if (fifo_rd || mail1_rd)
            begin
               b_data_out <= b_rd_word;
            end
         end
      end
   end

   assign mail_to_b_flag_n = mail_to_b_flag_q;
   assign mail_to_a_flag_n = mail_to_a_flag_q;

   // Events into the sticky status register
   wire [EW-1:0] events;
   assign events[dcfm_pkg::EV_A_PERR]   = a_wr & a_perr;
   assign events[dcfm_pkg::EV_B_PERR]   = b_wr & b_perr;
   assign events[dcfm_pkg::EV_MAIL_B]   = mail1_wr;
   assign events[dcfm_pkg::EV_MAIL_A]   = mail2_wr;
   assign events[dcfm_pkg::EV_WR_FULL]  = fifo_wr_req & ~fifo_wr;
   assign events[dcfm_pkg::EV_RD_EMPTY] = fifo_rd_req & ~fifo_rd;

   // AXI4-Lite slave: one write and one read in flight at most
   logic          aw_rdy_q;
   logic          w_rdy_q;
   logic          ar_rdy_q;
   logic [AW-1:0] awaddr_q;
   logic [31:0]   wdata_q;
   logic          wstrb0_q;
   logic [EW-1:0] status_q;
   logic [EW-1:0] mask_q;

   wire aw_hs   = s_axi_awvalid & aw_rdy_q;
   wire w_hs    = s_axi_wvalid & w_rdy_q;
   wire ar_hs   = s_axi_arvalid & ar_rdy_q;
   wire do_wr   = ~aw_rdy_q & ~w_rdy_q & ~s_axi_bvalid;
   wire wr_ctrl = do_wr & wstrb0_q & (awaddr_q == dcfm_pkg::CTRL_OFF);
   wire wr_mask = do_wr & wstrb0_q & (awaddr_q == dcfm_pkg::MASK_OFF);
   wire wr_ok   = (awaddr_q == dcfm_pkg::CTRL_OFF) || (awaddr_q == dcfm_pkg::MASK_OFF)
                  || (awaddr_q == dcfm_pkg::STATUS_OFF) || (awaddr_q == dcfm_pkg::LEVEL_OFF);
   wire st_clr  = ar_hs & (s_axi_araddr == dcfm_pkg::STATUS_OFF);
   wire [EW-1:0] status_d = (status_q & ~{EW{st_clr}}) | events;

   wire [5:0] flags_now = {mail_to_a_flag_q, mail_to_b_flag_q, ae_sync_q[1], ef_sync_q[1], af_sync_q[1],
                           ff_sync_q[1]};
   wire [31:0] level_word = {18'h0, flags_now, dcfm_pkg::CNT_FIELD_W'(count)};
   wire        rd_hit = (s_axi_araddr == dcfm_pkg::CTRL_OFF)
                        || (s_axi_araddr == dcfm_pkg::STATUS_OFF)
                        || (s_axi_araddr == dcfm_pkg::MASK_OFF)
                        || (s_axi_araddr == dcfm_pkg::LEVEL_OFF);
   wire [31:0] rd_word =
      (s_axi_araddr == dcfm_pkg::CTRL_OFF)   ? 32'(ctrl_odd_q) :
      (s_axi_araddr == dcfm_pkg::STATUS_OFF) ? 32'(status_q) :
      (s_axi_araddr == dcfm_pkg::MASK_OFF)   ? 32'(mask_q) :
      (s_axi_araddr == dcfm_pkg::LEVEL_OFF)  ? level_word : 32'h0;

   always_ff @(posedge core_clk)
   begin
      if (ce)
      begin
         if (rst)
         begin
            aw_rdy_q      <= 1'b1;
            w_rdy_q       <= 1'b1;
            ar_rdy_q      <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= dcfm_pkg::RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= dcfm_pkg::RESP_OKAY;
            s_axi_rdata   <= '0;
            ctrl_odd_q    <= dcfm_pkg::CTRL_ODD_RST;
            mask_q        <= '0;
            status_q      <= '0;
            irq           <= 1'b0;
         end
         else
         begin
            if (aw_hs)
            begin
               aw_rdy_q <= 1'b0;
               awaddr_q <= s_axi_awaddr;
            end
            if (w_hs)
            begin
               w_rdy_q  <= 1'b0;
               wdata_q  <= s_axi_wdata;
               wstrb0_q <= s_axi_wstrb[0];
            end
            if (do_wr)
            begin
               s_axi_bvalid <= 1'b1;
               s_axi_bresp  <= wr_ok ? dcfm_pkg::RESP_OKAY : dcfm_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
               s_axi_bvalid <= 1'b0;
               aw_rdy_q     <= 1'b1;
               w_rdy_q      <= 1'b1;
            end
            if (wr_ctrl)
            begin
               ctrl_odd_q <= wdata_q[dcfm_pkg::CTRL_ODD_BIT];
            end
            if (wr_mask)
            begin
               mask_q <= wdata_q[EW-1:0];
            end
            if (ar_hs)
            begin
               ar_rdy_q     <= 1'b0;
               s_axi_rvalid <= 1'b1;
               s_axi_rdata  <= rd_word;
               s_axi_rresp  <= rd_hit ? dcfm_pkg::RESP_OKAY : dcfm_pkg::RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
               s_axi_rvalid <= 1'b0;
               ar_rdy_q     <= 1'b1;
            end
            // New events win over the read-clear
            status_q <= status_d;
            irq      <= |(status_q & mask_q);
         end
      end
   end

   assign s_axi_awready = aw_rdy_q;
   assign s_axi_wready  = w_rdy_q;
   assign s_axi_arready = ar_rdy_q;
endmodule // dcfm_top

// [dcfm_pkg.sv]
// Purpose: Shared constants
// Assumes: Single core clock; port clocks arrive as sampled inputs
// Notes:   Offsets are AXI4-Lite byte addresses
package dcfm_pkg;
   localparam int         FIFO_DEPTH  = 64;
   localparam int         WORD_W      = 36;
   localparam int         BYTE_W      = 9;
   localparam int         RESET_EDGES = 4;
   localparam int         CNT_FIELD_W = 8;
   // Offset presets picked at reset release; plain defaults
   localparam int         OFFSET_PRESET [4] = '{16, 12, 8, 4};

   localparam int         AXI_AW      = 4;
   localparam logic [3:0] CTRL_OFF    = 4'h0;
   localparam logic [3:0] STATUS_OFF  = 4'h4;
   localparam logic [3:0] MASK_OFF    = 4'h8;
   localparam logic [3:0] LEVEL_OFF   = 4'hc;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int         CTRL_ODD_BIT = 0;
   localparam logic       CTRL_ODD_RST = 1'h0;

   localparam int         EV_W        = 6;
   localparam int         EV_A_PERR   = 0;
   localparam int         EV_B_PERR   = 1;
   localparam int         EV_MAIL_B   = 2;
   localparam int         EV_MAIL_A   = 3;
   localparam int         EV_WR_FULL  = 4;
   localparam int         EV_RD_EMPTY = 5;
endpackage

// [dcfm_par_if.sv]
// Purpose: Words and results for one parity unit
// Assumes: Word width a whole number of 9-bit bytes
// Notes:   One instance per port
`timescale 1ns/1ns
interface dcfm_par_if #(
   parameter int W = dcfm_pkg::WORD_W
);
   logic [W-1:0] chk_word;
   logic [W-1:0] gen_in;
   logic [W-1:0] gen_out;
   logic         odd;
   logic         err;
   modport unit (input chk_word, input gen_in, input odd, output gen_out, output err);
   modport user (output chk_word, output gen_in, output odd, input gen_out, input err);
endinterface

// [dcfm_parity.sv]
// Purpose: Per-byte parity check and generation
// Assumes: Top bit of each 9-bit byte is its parity bit
// Notes:   Purely combinational
`timescale 1ns/1ns
module dcfm_parity #(
   parameter int W = dcfm_pkg::WORD_W
) (
   dcfm_par_if.unit p
);
   localparam int BW = dcfm_pkg::BYTE_W;
   localparam int NB = W / BW;

   logic [NB-1:0] bad;

   for (genvar i = 0; i < NB; i++)
   begin : g_byte
      wire chk_par = ^p.chk_word[i*BW +: BW];
      wire gen_par = (^p.gen_in[i*BW +: BW-1]) ^ p.odd;
      assign bad[i] = chk_par ^ p.odd;
      assign p.gen_out[i*BW +: BW] = {gen_par, p.gen_in[i*BW +: BW-1]};
   end

   assign p.err = |bad;
endmodule // dcfm_parity

// [dcfm_assertions.sv]
// Purpose: Port-level checks of dcfm_top
// Assumes: Port clocks sampled by core_clk
// Notes:   A high full_flag_n stands in for reset hold having ended
`timescale 1ns/1ns
module dcfm_checker #(
   parameter int WIDTH = 36
) (
   input wire logic             core_clk,
   input wire logic             rst,
   input wire logic             ce,
   input wire logic             port_a_clock,
   input wire logic             a_side_select_n,
   input wire logic             a_side_gate,
   input wire logic             a_dir_select,
   input wire logic             a_mail_select,
   input wire logic             a_parity_gen,
   input wire logic             port_b_clock,
   input wire logic             b_side_select_n,
   input wire logic             b_side_gate,
   input wire logic             b_dir_select,
   input wire logic             b_mail_select,
   input wire logic [WIDTH-1:0] b_data_out,
   input wire logic             full_flag_n,
   input wire logic             empty_flag_n,
   input wire logic             mail_to_b_flag_n,
   input wire logic             mail_to_a_flag_n,
   input wire logic             a_parity_err_n
);
   logic pa_q;
   logic pb_q;
   wire  a_edge = port_a_clock && !pa_q;
   wire  b_edge = port_b_clock && !pb_q;
   wire  a_tk   = a_edge && !a_side_select_n && a_side_gate && ce;
   wire  b_tk   = b_edge && !b_side_select_n && b_side_gate && ce;
   wire  a_mwr  = a_tk && a_dir_select && a_mail_select;
   wire  a_mrd  = a_tk && !a_dir_select && a_mail_select;
   wire  b_mwr  = b_tk && b_dir_select && b_mail_select;
   wire  b_mrd  = b_tk && !b_dir_select && b_mail_select;
   always_ff @(posedge core_clk)
   begin
      pa_q <= port_a_clock;
      pb_q <= port_b_clock;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_reset_flags: assert property (disable iff (1'h0) rst |=>
      {full_flag_n, empty_flag_n, mail_to_b_flag_n, mail_to_a_flag_n} == 4'h3)
      else $error("reset flags");
   a_full_on_a: assert property (!$past(rst) && $changed(full_flag_n) |-> $past(a_edge))
      else $error("full off A edge");
   a_empty_on_b: assert property (!$past(rst) && $changed(empty_flag_n) |-> $past(b_edge))
      else $error("empty off B edge");
   a_mail_fills: assert property (a_mwr && mail_to_b_flag_n && full_flag_n && !b_mrd
      |=> !mail_to_b_flag_n) else $error("mail1 flag stuck");
   a_mail_back: assert property (b_mwr && mail_to_a_flag_n && full_flag_n && !a_mrd
      |=> !mail_to_a_flag_n) else $error("mail2 flag stuck");
   a_mail_clears: assert property (b_mrd && !a_mwr |=> mail_to_b_flag_n)
      else $error("mail1 flag not raised");
   a_mail_blocks: assert property (a_mwr && !mail_to_b_flag_n && !b_mrd |=> !mail_to_b_flag_n)
      else $error("blocked mail write");
   a_gen_quiet: assert property (!a_side_select_n && a_side_gate && !a_dir_select
      && a_mail_select && a_parity_gen |=> a_parity_err_n) else $error("parity err not forced");
   a_bout_hold: assert property (!(b_tk && !b_dir_select) |=> $stable(b_data_out))
      else $error("B data moved");
   c_mail_write: cover property (a_mwr);
   c_queue_read: cover property (b_tk && !b_dir_select && !b_mail_select);
   c_full: cover property ($fell(full_flag_n));
endmodule // dcfm_checker

bind dcfm_top dcfm_checker #(.WIDTH(WIDTH)) chk (.*);

// [dcfm_port_model.sv]
// Purpose: Bus controller on one port
// Assumes: Requests held over the sampling edge
// Notes:   Released lines show the inverse word
`timescale 1ns/1ns
module dcfm_port_model #(
   parameter int HALF = 2
) (
   input  wire logic        core_clk,
   output logic             port_clk = 1'h0,
   output logic             sel_n = 1'h1,
   output logic             gate = 1'h0,
   output logic             dir = 1'h0,
   output logic             mail = 1'h0,
   output logic             pgen = 1'h0,
   output logic [35:0]      drv = 36'h0,
   input  wire logic [35:0] wire_in
);
   int cnt = 0;
   // Runs through reset
   always @(posedge core_clk)
   begin
      cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
         port_clk <= 1'h1;
      if (cnt == 2 * HALF - 1)
         port_clk <= 1'h0;
   end
   task automatic xfer(input logic d, input logic m, input logic g, input logic [35:0] w,
                       output logic [35:0] r);
      @(posedge core_clk iff cnt == HALF - 1);
      sel_n <= 1'h0;
      gate <= 1'h1;
      dir <= d;
      mail <= m;
      pgen <= g;
      drv <= w;
      @(posedge core_clk);
      sel_n <= 1'h1;
      gate <= 1'h0;
      drv <= ~w;
      #1 r = wire_in;
   endtask
endmodule // dcfm_port_model

// [dual_clock_fifo_with_mailboxes_test.sv]
// Purpose: Self-checking bench for dcfm_top
// Assumes: Offset preset 0 (16 words); port B slower than port A
// Notes:   Flag waits span several port edges
`timescale 1ns/1ns
module dual_clock_fifo_with_mailboxes_test;
   logic        core_clk = 1'h0;
   logic        rst = 1'h1;
   logic        ce = 1'h1;
   logic        port_a_clock, a_side_select_n, a_side_gate, a_dir_select, a_mail_select;
   logic        a_parity_gen, a_data_oe, port_b_clock, b_side_select_n, b_side_gate;
   logic        b_dir_select, b_mail_select, b_parity_gen, b_data_oe, full_flag_n;
   logic        almost_full_flag_n, empty_flag_n, almost_empty_flag_n, mail_to_b_flag_n;
   logic        mail_to_a_flag_n, a_parity_err_n, b_parity_err_n, irq;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  threshold_preset_pick = 2'h0, s_axi_bresp, s_axi_rresp;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, s;
   logic [35:0] a_data_out, b_data_out, a_drv, b_drv, r;
   wire  [35:0] a_data_in = a_data_oe ? a_data_out : a_drv;
   wire  [35:0] b_data_in = b_data_oe ? b_data_out : b_drv;
   wire  [5:0]  flags = {full_flag_n, almost_full_flag_n, empty_flag_n, almost_empty_flag_n,
                         mail_to_b_flag_n, mail_to_a_flag_n};
   int          miscompares = 0;
   int          num_checks = 0;

   dcfm_top DUT (.*);
   dcfm_port_model #(.HALF(2)) pa (.core_clk, .port_clk(port_a_clock), .sel_n(a_side_select_n),
      .gate(a_side_gate), .dir(a_dir_select), .mail(a_mail_select), .pgen(a_parity_gen),
      .drv(a_drv), .wire_in(a_data_in));
   dcfm_port_model #(.HALF(3)) pb (.core_clk, .port_clk(port_b_clock), .sel_n(b_side_select_n),
      .gate(b_side_gate), .dir(b_dir_select), .mail(b_mail_select), .pgen(b_parity_gen),
      .drv(b_drv), .wire_in(b_data_in));

   always #10 core_clk = ~core_clk;

   task automatic chk(input logic [35:0] g, input logic [35:0] e);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask

   function automatic logic [35:0] par(input logic [35:0] w, input logic odd);
      for (int i = 0; i < 4; i++)
         w[9*i+8] = ^w[9*i +: 8] ^ odd;
      return w;
   endfunction

   function automatic logic [35:0] wd(input int i);
      return {4'(i), 16'(~i), 16'(i)};
   endfunction

   task automatic axw(input logic [3:0] ad, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask

   task automatic axr(input logic [3:0] ad, output logic [31:0] d);
      @(posedge core_clk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      s_axi_rready <= 1'h0;
   endtask

   task automatic t_parity;
      axw(4'h0, 32'h0);
      pa.xfer(1'h1, 1'h0, 1'h0, 36'h1, r);
      chk(a_parity_err_n, 36'h0);
      pa.xfer(1'h1, 1'h0, 1'h0, 36'h1_2345_6789, r);
      axr(4'h4, s);
      chk(s[0], 36'h1);
      repeat (30) @(posedge core_clk);
      pb.xfer(1'h0, 1'h0, 1'h0, 36'h0, r);
      chk(r, 36'h1);
      axw(4'h0, 32'h1);
      pb.xfer(1'h0, 1'h0, 1'h1, 36'h0, r);
      chk(r, par(36'h1_2345_6789, 1'h1));
   endtask

   task automatic t_mail;
      pa.xfer(1'h1, 1'h1, 1'h0, 36'h0_aaaa_5555, r);
      chk(mail_to_b_flag_n, 36'h0);
      pa.xfer(1'h1, 1'h1, 1'h0, 36'h0_1111_2222, r);
      pb.xfer(1'h0, 1'h1, 1'h0, 36'h0, r);
      chk(r, 36'h0_aaaa_5555);
      chk(mail_to_b_flag_n, 36'h1);
      pb.xfer(1'h1, 1'h1, 1'h0, 36'h3_0f0f_0f0f, r);
      chk(mail_to_a_flag_n, 36'h0);
      pa.xfer(1'h0, 1'h1, 1'h1, 36'h0, r);
      chk(r, par(36'h3_0f0f_0f0f, 1'h1));
      axr(4'h4, s);
      chk(s[3:2], 36'h3);
   endtask

   task automatic t_fill_drain;
      axw(4'h8, 32'h10);
      for (int i = 0; i < 64; i++)
      begin
         pa.xfer(1'h1, 1'h0, 1'h0, wd(i), r);
         if (i == 46 || i == 47)
         begin
            repeat (16) @(posedge core_clk);
            chk(almost_full_flag_n, i == 46);
         end
      end
      pa.xfer(1'h1, 1'h0, 1'h0, 36'h0, r);
      repeat (16) @(posedge core_clk);
      chk({full_flag_n, irq}, 36'h1);
      axr(4'hc, s);
      chk(s[9:0], 36'h40);
      axr(4'h4, s);
      chk(s[4], 36'h1);
      repeat (2) @(posedge core_clk);
      chk(irq, 36'h0);
      for (int i = 0; i < 64; i++)
      begin
         pb.xfer(1'h0, 1'h0, 1'h0, 36'h0, r);
         chk(r, wd(i));
         if (i == 46 || i == 47)
         begin
            repeat (24) @(posedge core_clk);
            chk(almost_empty_flag_n, i == 46);
         end
      end
      repeat (24) @(posedge core_clk);
      pb.xfer(1'h0, 1'h0, 1'h0, 36'h0, r);
      chk(r, wd(63));
      chk(empty_flag_n, 36'h0);
      repeat (2) @(posedge core_clk);
      chk(irq, 36'h0);
      axr(4'h4, s);
      chk(s[5], 36'h1);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      #1000000;
      miscompares++;
      tally_and_finish;
   end

   initial
   begin
      repeat (2) @(posedge core_clk);
      #1 chk(flags, 36'h13);
      repeat (2) @(posedge core_clk);
      rst <= 1'h0;
      repeat (60) @(posedge core_clk);
      chk(flags, 36'h33);
      t_parity;
      t_mail;
      t_fill_drain;
      tally_and_finish;
   end
endmodule // dual_clock_fifo_with_mailboxes_test
